// ---- rtl/charge_time_unit.sv ----
// Charge-time unit edge control with AXI4-Lite register slave
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module charge_time_unit (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [3:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire charge_time_pkg::edge_in_t edges_i,
  input wire logic idle_i,
  input wire logic sleep_i,
  input wire logic comp_trip_i,
  output charge_time_pkg::analog_ctl_t analog_o,
  output logic converter_trigger_o,
  output logic delay_pulse_pin_o,
  output logic unit_irq_flag_o
);
  logic [7:0] ctrl_high_r;
  logic [7:0] edge_ctrl_r;
  logic [7:0] current_r;
  logic module_clock_disable_r;
  logic irq_flag_r;
  logic [3:0] edges_prev_r;
  logic trip_prev_r;
  logic [3:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic wr_go;
  logic wr_lane0;
  logic first_hit;
  logic second_hit;
  logic run;
  logic first_set;
  logic second_set;
  logic trip_rise;

  // Pick the selected source bit out of the sampled edge inputs
  function automatic logic pick_src(input logic [1:0] sel, input logic [3:0] v);
    logic r;
    r = 1'b0;
    unique case (sel)
      charge_time_pkg::SRC_PIN_ONE: r = v[3];
      charge_time_pkg::SRC_PIN_TWO: r = v[2];
      charge_time_pkg::SRC_PWM_ONE: r = v[1];
      charge_time_pkg::SRC_PWM_TWO: r = v[0];
    endcase
    return r;
  endfunction

  // Edge of chosen polarity between previous and current sample
  function automatic logic edge_hit(input logic pol, input logic prev, input logic cur);
    return pol ? (cur & ~prev) : (prev & ~cur);
  endfunction

  // Clock gate stands in for a gated clock: edge history, status bits and output events stop while disabled
  assign run = ctrl_high_r[charge_time_pkg::UNIT_ENABLE_BIT] & ~module_clock_disable_r
    & ~(idle_i & ctrl_high_r[charge_time_pkg::STOP_IN_IDLE_BIT]);

  assign first_hit = edge_hit(edge_ctrl_r[charge_time_pkg::FIRST_POL_BIT],
    pick_src(edge_ctrl_r[charge_time_pkg::FIRST_SRC_LSB +: 2], edges_prev_r),
    pick_src(edge_ctrl_r[charge_time_pkg::FIRST_SRC_LSB +: 2], edges_i));
  assign second_hit = edge_hit(edge_ctrl_r[charge_time_pkg::SECOND_POL_BIT],
    pick_src(edge_ctrl_r[charge_time_pkg::SECOND_SRC_LSB +: 2], edges_prev_r),
    pick_src(edge_ctrl_r[charge_time_pkg::SECOND_SRC_LSB +: 2], edges_i));

  // Blocked edges never reach the status bits
  assign first_set = run & ctrl_high_r[charge_time_pkg::EDGE_PASS_ENABLE_BIT] & first_hit;
  assign second_set = run & ctrl_high_r[charge_time_pkg::EDGE_PASS_ENABLE_BIT] & second_hit
    & (~ctrl_high_r[charge_time_pkg::EDGE_ORDER_ENABLE_BIT]
    | edge_ctrl_r[charge_time_pkg::FIRST_SEEN_BIT]);

  assign trip_rise = comp_trip_i & ~trip_prev_r;

  // Write happens once both address and data are held and no response pending
  assign wr_go = aw_held_r & w_held_r & ~bvalid_o;
  assign wr_lane0 = wr_go & wstrb_r[0];

  // Edge input history, only sampled while the unit is clocked; comparator trip history sampled every cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edges_prev_r <= 4'h0;
      trip_prev_r <= 1'b0;
    end else begin
      if (run) begin
        edges_prev_r <= edges_i;
      end
      trip_prev_r <= comp_trip_i;
    end
  end

  // Control register 0; bit 6 is never stored
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_high_r <= charge_time_pkg::CTRL_HIGH_RST;
    end else if (wr_lane0 && awaddr_r == charge_time_pkg::CTRL_HIGH_ADDR) begin
      ctrl_high_r <= wdata_r[7:0] & charge_time_pkg::CTRL_HIGH_MASK;
    end
  end

  // Control register 1; hardware set wins over a same-cycle software clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edge_ctrl_r <= charge_time_pkg::EDGE_CTRL_RST;
    end else begin
      if (wr_lane0 && awaddr_r == charge_time_pkg::EDGE_CTRL_ADDR) begin
        edge_ctrl_r <= wdata_r[7:0];
        if (first_set) begin
          edge_ctrl_r[charge_time_pkg::FIRST_SEEN_BIT] <= 1'b1;
        end
        if (second_set) begin
          edge_ctrl_r[charge_time_pkg::SECOND_SEEN_BIT] <= 1'b1;
        end
      end else begin
        if (first_set) begin
          edge_ctrl_r[charge_time_pkg::FIRST_SEEN_BIT] <= 1'b1;
        end
        if (second_set) begin
          edge_ctrl_r[charge_time_pkg::SECOND_SEEN_BIT] <= 1'b1;
        end
      end
    end
  end

  // Current trim and range register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      current_r <= charge_time_pkg::CURRENT_RST;
    end else if (wr_lane0 && awaddr_r == charge_time_pkg::CURRENT_ADDR) begin
      current_r <= wdata_r[7:0];
    end
  end

  // Module disable and sticky flag; a new sequence end beats a clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      module_clock_disable_r <= 1'b0;
      irq_flag_r <= 1'b0;
    end else begin
      if (wr_lane0 && awaddr_r == charge_time_pkg::MOD_CTRL_ADDR) begin
        module_clock_disable_r <= wdata_r[charge_time_pkg::MODULE_DISABLE_BIT];
        if (wdata_r[charge_time_pkg::IRQ_FLAG_BIT]) begin
          irq_flag_r <= 1'b0;
        end
      end
      if (second_set) begin
        irq_flag_r <= 1'b1;
      end
    end
  end

  // Analog control: source runs while exactly one status bit stands
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      analog_o <= '0;
    end else begin
      analog_o.source_on <= run & ~sleep_i
        & (current_r[charge_time_pkg::RANGE_LSB +: 2] != charge_time_pkg::RANGE_OFF)
        & (edge_ctrl_r[charge_time_pkg::FIRST_SEEN_BIT]
        ^ edge_ctrl_r[charge_time_pkg::SECOND_SEEN_BIT]);
      analog_o.discharge <= ctrl_high_r[charge_time_pkg::SOURCE_DISCHARGE_BIT];
      analog_o.trim <= current_r[charge_time_pkg::TRIM_LSB +: 6];
      analog_o.range <= current_r[charge_time_pkg::RANGE_LSB +: 2];
    end
  end

  // Event outputs: converter trigger at sequence end, delay pulse at trip
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      converter_trigger_o <= 1'b0;
      delay_pulse_pin_o <= 1'b0;
      unit_irq_flag_o <= 1'b0;
    end else begin
      converter_trigger_o <= second_set
        & ctrl_high_r[charge_time_pkg::CONVERTER_TRIGGER_BIT];
      delay_pulse_pin_o <= run & trip_rise
        & ctrl_high_r[charge_time_pkg::DELAY_GEN_ENABLE_BIT];
      unit_irq_flag_o <= irq_flag_r;
    end
  end

  // AXI write channels: address and data taken in either order
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= 2'h0;
    end else begin
      awready_o <= ~aw_held_r & ~awready_o & ~bvalid_o;
      wready_o <= ~w_held_r & ~wready_o & ~bvalid_o;
      if (awvalid_i && awready_o) begin
        aw_held_r <= 1'b1;
        awaddr_r <= awaddr_i;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_held_r <= 1'b1;
        wdata_r <= wdata_i;
        wstrb_r <= wstrb_i;
        wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= (awaddr_r > charge_time_pkg::MOD_CTRL_ADDR || awaddr_r[1:0] != 2'b00)
          ? 2'b10 : 2'b00; // Unmapped answers SLVERR
        awready_o <= 1'b0;
        wready_o <= 1'b0;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // AXI read channel; unused upper bits and bit 6 read as zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0;
      rresp_o <= 2'h0;
    end else begin
      arready_o <= ~arready_o & ~rvalid_o;
      if (arvalid_i && arready_o) begin
        arready_o <= 1'b0;
        rvalid_o <= 1'b1;
        rresp_o <= 2'b00;
        unique case (araddr_i)
          charge_time_pkg::CTRL_HIGH_ADDR: rdata_o <= {24'h0, ctrl_high_r};
          charge_time_pkg::EDGE_CTRL_ADDR: rdata_o <= {24'h0, edge_ctrl_r};
          charge_time_pkg::CURRENT_ADDR: rdata_o <= {24'h0, current_r};
          charge_time_pkg::MOD_CTRL_ADDR: rdata_o <= {30'h0, irq_flag_r, module_clock_disable_r};
          default: begin
            rdata_o <= 32'h0;
            rresp_o <= 2'b10;
          end
        endcase
      end else if (rvalid_o && rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end

  // Checks: register effects are watched, not only the set strobes, so a broken gate shows
  ctrl_bit6_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ctrl_high_r[charge_time_pkg::UNUSED_BIT])
    else $error("control bit 6 stored");
  first_seen_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    first_set |=> edge_ctrl_r[charge_time_pkg::FIRST_SEEN_BIT])
    else $error("edge 1 lost");
  second_seen_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    second_set |=> edge_ctrl_r[charge_time_pkg::SECOND_SEEN_BIT])
    else $error("edge 2 lost");
  first_seen_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    edge_ctrl_r[charge_time_pkg::FIRST_SEEN_BIT] && !wr_lane0
    |=> edge_ctrl_r[charge_time_pkg::FIRST_SEEN_BIT])
    else $error("edge 1 status dropped");
  order_block_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ctrl_high_r[charge_time_pkg::EDGE_ORDER_ENABLE_BIT]
    && !edge_ctrl_r[charge_time_pkg::FIRST_SEEN_BIT]) |-> !second_set)
    else $error("edge 2 before edge 1");
  edges_blocked_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ctrl_high_r[charge_time_pkg::EDGE_PASS_ENABLE_BIT] && !wr_lane0
    |=> $stable(edge_ctrl_r))
    else $error("blocked edge set status");
  disabled_frozen_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !run && !wr_lane0
    |=> $stable(edge_ctrl_r))
    else $error("status changed while stopped");
  source_xor_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    analog_o.source_on |-> $past(edge_ctrl_r[charge_time_pkg::FIRST_SEEN_BIT]
    ^ edge_ctrl_r[charge_time_pkg::SECOND_SEEN_BIT]) && !$past(sleep_i))
    else $error("source on wrongly");
  sleep_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sleep_i |=> !analog_o.source_on)
    else $error("source on in sleep");
  stopped_source_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !run |=> !analog_o.source_on)
    else $error("source on while stopped");
  range_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    analog_o.source_on |-> $past(current_r[charge_time_pkg::RANGE_LSB +: 2]) != 2'b00)
    else $error("source on with range off");
  current_follow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    analog_o.trim == $past(current_r[charge_time_pkg::TRIM_LSB +: 6])
    && analog_o.range == $past(current_r[charge_time_pkg::RANGE_LSB +: 2]))
    else $error("trim or range mismatch");
  discharge_follow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    analog_o.discharge == $past(ctrl_high_r[charge_time_pkg::SOURCE_DISCHARGE_BIT]))
    else $error("discharge mismatch");
  trigger_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    converter_trigger_o |-> $past(ctrl_high_r[charge_time_pkg::CONVERTER_TRIGGER_BIT]))
    else $error("trigger not enabled");
  trigger_fire_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    second_set && ctrl_high_r[charge_time_pkg::CONVERTER_TRIGGER_BIT] |=> converter_trigger_o)
    else $error("trigger missing");
  pulse_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    delay_pulse_pin_o |-> $past(ctrl_high_r[charge_time_pkg::DELAY_GEN_ENABLE_BIT] & run))
    else $error("pulse not enabled");
  pulse_fire_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    run && trip_rise && ctrl_high_r[charge_time_pkg::DELAY_GEN_ENABLE_BIT] |=> delay_pulse_pin_o)
    else $error("delay pulse missing");
  irq_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    second_set |=> irq_flag_r)
    else $error("flag not raised");
  irq_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    irq_flag_r && !wr_lane0 |=> irq_flag_r)
    else $error("flag dropped");
endmodule

// ---- rtl/charge_time_pkg.sv ----
// Package: register map, field positions and shared types of the charge-time unit
package charge_time_pkg;
  // Register byte addresses (word aligned)
  localparam logic [3:0] CTRL_HIGH_ADDR = 4'h0;
  localparam logic [3:0] EDGE_CTRL_ADDR = 4'h4;
  localparam logic [3:0] CURRENT_ADDR = 4'h8;
  localparam logic [3:0] MOD_CTRL_ADDR = 4'hc;
  // Reset values
  localparam logic [7:0] CTRL_HIGH_RST = 8'h00;
  localparam logic [7:0] EDGE_CTRL_RST = 8'h00;
  localparam logic [7:0] CURRENT_RST = 8'h00;
  localparam logic [7:0] MOD_CTRL_RST = 8'h00;
  // Control register 0 fields
  localparam int UNIT_ENABLE_BIT = 7;
  localparam int UNUSED_BIT = 6;
  localparam int STOP_IN_IDLE_BIT = 5;
  localparam int DELAY_GEN_ENABLE_BIT = 4;
  localparam int EDGE_PASS_ENABLE_BIT = 3;
  localparam int EDGE_ORDER_ENABLE_BIT = 2;
  localparam int SOURCE_DISCHARGE_BIT = 1;
  localparam int CONVERTER_TRIGGER_BIT = 0;
  localparam logic [7:0] CTRL_HIGH_MASK = 8'hbf;
  // Control register 1 fields
  localparam int SECOND_POL_BIT = 7;
  localparam int SECOND_SRC_LSB = 5;
  localparam int FIRST_POL_BIT = 4;
  localparam int FIRST_SRC_LSB = 2;
  localparam int SECOND_SEEN_BIT = 1;
  localparam int FIRST_SEEN_BIT = 0;
  // Current register fields
  localparam int TRIM_LSB = 2;
  localparam int RANGE_LSB = 0;
  // Module control register fields (own register)
  localparam int MODULE_DISABLE_BIT = 0;
  localparam int IRQ_FLAG_BIT = 1;
  // Edge source codes
  typedef enum logic [1:0] {
    SRC_PWM_TWO = 2'b00,
    SRC_PWM_ONE = 2'b01,
    SRC_PIN_TWO = 2'b10,
    SRC_PIN_ONE = 2'b11
  } edge_src_t;
  // Current range codes
  typedef enum logic [1:0] {
    RANGE_OFF = 2'b00,
    RANGE_BASE = 2'b01,
    RANGE_TEN = 2'b10,
    RANGE_HUNDRED = 2'b11
  } range_t;
  // Edge source inputs travelling together
  typedef struct packed {
    logic pin_one;
    logic pin_two;
    logic pwm_one;
    logic pwm_two;
  } edge_in_t;
  // Analog control outputs travelling together
  typedef struct packed {
    logic source_on;
    logic discharge;
    logic [5:0] trim;
    logic [1:0] range;
  } analog_ctl_t;
endpackage

// ---- testbench/edge_source_model.sv ----
// Far-side model: edge pins, PWM trigger lines and the converter's trigger input
`timescale 1ns/1ps
module edge_source_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] toggle_i,
  input wire logic conv_trig_i,
  output charge_time_pkg::edge_in_t edges_o,
  output logic [7:0] trig_cnt_o
);
  // Source lines change only on a clock edge, so every edge is seen by a synchronous sampler
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edges_o <= '0;
    end else begin
      edges_o <= edges_o ^ toggle_i;
    end
  end
  // Converter side counts start-of-conversion pulses it receives
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_cnt_o <= 8'h00;
    end else if (conv_trig_i) begin
      trig_cnt_o <= trig_cnt_o + 8'h01;
    end
  end
endmodule

// ---- testbench/charge_time_edge_control_tb_top.sv ----
// Testbench: register access over AXI4-Lite and edge sequencing scenarios
`timescale 1ns/1ps
module charge_time_edge_control_tb_top;
  localparam logic [3:0] A_C0 = charge_time_pkg::CTRL_HIGH_ADDR;
  localparam logic [3:0] A_C1 = charge_time_pkg::EDGE_CTRL_ADDR;
  localparam logic [3:0] A_CUR = charge_time_pkg::CURRENT_ADDR;
  localparam logic [3:0] A_MOD = charge_time_pkg::MOD_CTRL_ADDR;
  logic clk_i, nrst_i, awvalid, wvalid, bready, arvalid, rready, idle_i, sleep_i, comp_trip_i;
  logic [3:0] awaddr, araddr, toggle;
  logic [31:0] wdata, rdata_o, rd;
  logic [1:0] bresp_o, rresp_o, rr;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, conv_trig, pls_o, irq_o;
  logic [7:0] trig_cnt, cfg;
  charge_time_pkg::edge_in_t edges;
  charge_time_pkg::analog_ctl_t analog_o;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int c;
  charge_time_unit i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .awaddr_i(awaddr),
    .awvalid_i(awvalid), .awready_o(awready_o), .wdata_i(wdata), .wstrb_i(4'h1),
    .wvalid_i(wvalid), .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
    .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready_o),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready),
    .edges_i(edges), .idle_i(idle_i), .sleep_i(sleep_i), .comp_trip_i(comp_trip_i),
    .analog_o(analog_o), .converter_trigger_o(conv_trig), .delay_pulse_pin_o(pls_o),
    .unit_irq_flag_o(irq_o));
  edge_source_model i_src (.clk_i(clk_i), .nrst_i(nrst_i), .toggle_i(toggle),
    .conv_trig_i(conv_trig), .edges_o(edges), .trig_cnt_o(trig_cnt));
  // Clock at 25 MHz
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs a few thousand cycles at most
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Address and data offered together, each released at its own handshake
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_i);
      if (!aw_done && awready_o) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready_o) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    bready <= 1'b1;
    do @(posedge clk_i); while (bvalid_o !== 1'b1);
    chk("write resp", 32'(bresp_o), 32'h0);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_i); while (arready_o !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk_i); while (rvalid_o !== 1'b1);
    d = rdata_o;
    r = rresp_o;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(nm, d, e);
    chk(nm, 32'(r), 32'h0);
  endtask
  // One toggle of the selected source lines, then time for the status to settle
  task automatic pulse(input logic [3:0] m);
    toggle <= m;
    @(posedge clk_i);
    toggle <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic trip(output int n);
    n = 0;
    comp_trip_i <= 1'b1;
    repeat (6) begin
      @(posedge clk_i);
      if (pls_o === 1'b1) n++;
    end
    comp_trip_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    {nrst_i, awvalid, wvalid, bready, arvalid, rready, idle_i, sleep_i, comp_trip_i} = '0;
    {awaddr, araddr, toggle, wdata} = '0;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd_chk(A_C0, 32'h0, "ctrl0 reset");
    rd_chk(A_C1, 32'h0, "ctrl1 reset");
    rd_chk(A_CUR, 32'h0, "current reset");
    rd_chk(A_MOD, 32'h0, "module reset");
    axi_rd(4'h2, rd, rr);
    chk("unmapped resp", 32'(rr), 32'h2);
    axi_wr(A_C0, 32'hff);
    rd_chk(A_C0, 32'hbf, "ctrl0 bit6");
    chk("discharge on", 32'(analog_o.discharge), 32'h1);
    axi_wr(A_C0, 32'h00);
    @(posedge clk_i);
    chk("discharge off", 32'(analog_o.discharge), 32'h0);
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'h7d : (i == 1) ? 8'h86 : (i == 2) ? 8'h03 : 8'h00;
      axi_wr(A_CUR, 32'(c));
      rd_chk(A_CUR, 32'(c), "current rw");
      chk("trim out", 32'(analog_o.trim), 32'(c[7:2]));
      chk("range out", 32'(analog_o.range), 32'(c[1:0]));
    end
    axi_wr(A_C0, 32'h88);
    axi_wr(A_CUR, 32'h01);
    for (int ch = 0; ch < 2; ch++) begin
      for (int pol = 0; pol < 2; pol++) begin
        for (int s = 0; s < 4; s++) begin
          cfg = (ch == 0) ? 8'(pol * 16 + s * 4 + (s ^ 1) * 32) :
                8'(pol * 128 + s * 32 + (s ^ 1) * 4);
          axi_wr(A_C1, 32'(cfg));
          pulse(4'(1 << s));
          rd_chk(A_C1, 32'(cfg) | 32'(pol << ch), "first line edge");
          chk("source one seen", 32'(analog_o.source_on), 32'(pol));
          pulse(4'(1 << s));
          rd_chk(A_C1, 32'(cfg) | 32'(1 << ch), "second line edge");
        end
      end
    end
    // Sequenced measurement with converter trigger enabled; flag cleared first
    axi_wr(A_MOD, 32'h2);
    axi_wr(A_C0, 32'h8d);
    axi_wr(A_C1, 32'hf8);
    pulse(4'h8);
    pulse(4'h8);
    rd_chk(A_C1, 32'hf8, "edge2 before edge1");
    pulse(4'h4);
    rd_chk(A_C1, 32'hf9, "edge1 seen");
    chk("charging", 32'(analog_o.source_on), 32'h1);
    pulse(4'h8);
    rd_chk(A_C1, 32'hfb, "edge2 seen");
    chk("both seen", 32'(analog_o.source_on), 32'h0);
    chk("conv trig", 32'(trig_cnt), 32'h1);
    chk("irq out", 32'(irq_o), 32'h1);
    rd_chk(A_MOD, 32'h2, "irq flag");
    axi_wr(A_MOD, 32'h2);
    rd_chk(A_MOD, 32'h0, "irq cleared");
    // Edges blocked, then stopped in Idle, then running again
    axi_wr(A_C0, 32'h80);
    axi_wr(A_C1, 32'hf8);
    pulse(4'h4);
    pulse(4'h4);
    rd_chk(A_C1, 32'hf8, "edges blocked");
    axi_wr(A_C0, 32'ha8);
    idle_i <= 1'b1;
    pulse(4'h4);
    pulse(4'h4);
    rd_chk(A_C1, 32'hf8, "stopped in idle");
    idle_i <= 1'b0;
    pulse(4'h4);
    pulse(4'h4);
    rd_chk(A_C1, 32'hf9, "running again");
    sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("sleep off", 32'(analog_o.source_on), 32'h0);
    sleep_i <= 1'b0;
    axi_wr(A_C1, 32'hf8);
    axi_wr(A_MOD, 32'h1);
    pulse(4'h4);
    pulse(4'h4);
    rd_chk(A_C1, 32'hf8, "module off");
    axi_wr(A_MOD, 32'h0);
    axi_wr(A_C0, 32'h98);
    trip(c);
    chk("delay pulse", 32'(c), 32'h1);
    axi_wr(A_C0, 32'h88);
    trip(c);
    chk("no delay pulse", 32'(c), 32'h0);
    pulse(4'h4);
    pulse(4'h4);
    // Reset in mid-measurement, then read back the cleared status and control 0
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("analog in reset", 32'(analog_o), 32'h0);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd_chk(A_C1, 32'h0, "status lost");
    rd_chk(A_C0, 32'h0, "ctrl0 cleared");
    final_report();
  end
endmodule
